// ==== rtl/cat_loader.sv ====
// channel activity table loader: scanner, table load pointers, memory stealing
`timescale 1ns/10ps
`default_nettype none
module cat_loader #(
	parameter int LINES = cat_pkg::CAT_BASIC_LINES,
	parameter int GROUP = cat_pkg::CAT_BASIC_LINES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	cat_link_if.loader link,
	input wire logic prio_unload_step,
	input wire logic gen_unload_step,
	output logic [cat_pkg::CAT_PRIO_PTR_W-1:0] priority_table_load_pointer,
	output logic [cat_pkg::CAT_GEN_PTR_W-1:0] general_table_load_pointer,
	output logic [cat_pkg::CAT_PRIO_PTR_W-1:0] priority_table_unload_pointer,
	output logic [cat_pkg::CAT_GEN_PTR_W-1:0] general_table_unload_pointer,
	output logic busy
);
	import cat_pkg::*;
	localparam int SW = (LINES > 1) ? $clog2(LINES) : 1;
	localparam int GW = (GROUP > 1) ? $clog2(GROUP) : 1;
	localparam int UW = (LINES / GROUP > 1) ? $clog2(LINES / GROUP) : 1;

	cat_state_t state_reg;
	logic [SW-1:0] scan_reg;
	logic is_out_reg;
	logic fast_reg;
	logic [CAT_CHAR_W-1:0] char_reg;
	logic [CAT_DATA_W-1:0] rdword_reg;
	logic [GW-1:0] mod_pos;
	logic [UW-1:0] unit_pos;
	logic [CAT_LINE_W-1:0] line_num;
	logic [CAT_DATA_W-1:0] entry;

	function automatic logic [CAT_ADDR_W-1:0] char_word_addr(input logic [CAT_LINE_W-1:0] ln);
		char_word_addr = CAT_LOCT_BASE + CAT_ADDR_W'(ln >> 2);
	endfunction

	// module scanner and line-unit scanner positions
	assign mod_pos = scan_reg[GW-1:0];
	assign unit_pos = (LINES > GROUP) ? UW'(scan_reg >> GW) : '0;
	assign line_num = CAT_LINE_W'({unit_pos, mod_pos});

	// type flag, line address, character; upper portion unused
	always_comb begin
		entry = '0;
		entry[CAT_TYPE_BIT] = is_out_reg ? CAT_TYPE_OUTPUT : CAT_TYPE_INPUT;
		entry[CAT_LINE_LSB +: CAT_CHAR_W] = CAT_CHAR_W'(line_num);
		entry[CAT_CHAR_LSB +: CAT_CHAR_W] = is_out_reg ? CAT_CHAR_ZERO : char_reg;
	end

	// scanner and service sequence
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= CAT_SCAN;
			scan_reg <= '0;
			is_out_reg <= 1'b0;
			fast_reg <= 1'b0;
			char_reg <= CAT_CHAR_ZERO;
		end else begin
			case (state_reg)
				CAT_SCAN: begin
					if (link.out_avail[scan_reg]) begin
						is_out_reg <= 1'b1;
						fast_reg <= link.out_fast[scan_reg];
						state_reg <= CAT_RD_REQ;
					end else if (link.in_ready[scan_reg]) begin
						is_out_reg <= 1'b0;
						fast_reg <= 1'b0;
						// taken raw; parity left for software
						char_reg <= link.in_char[scan_reg*CAT_CHAR_W +: CAT_CHAR_W];
						state_reg <= CAT_WR_REQ;
					end else begin
						scan_reg <= (scan_reg == SW'(LINES - 1)) ? '0 : scan_reg + 1'b1;
					end
				end
				CAT_RD_REQ: begin
					if (link.mem_gnt) begin
						state_reg <= CAT_RD_WAIT;
					end
				end
				CAT_RD_WAIT: begin
					if (link.mem_rvalid) begin
						state_reg <= CAT_HAND;
					end
				end
				CAT_HAND: begin
					state_reg <= CAT_WR_REQ;
				end
				CAT_WR_REQ: begin
					if (link.mem_gnt) begin
						state_reg <= CAT_RELEASE;
					end
				end
				CAT_RELEASE: begin
					scan_reg <= (scan_reg == SW'(LINES - 1)) ? '0 : scan_reg + 1'b1;
					state_reg <= CAT_SCAN;
				end
				default: begin
					state_reg <= CAT_SCAN;
				end
			endcase
		end
	end

	// latch the whole read word; the character is picked at hand-off by the two low address bits of the line
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdword_reg <= '0;
		end else if (state_reg == CAT_RD_WAIT && link.mem_rvalid) begin
			rdword_reg <= link.mem_rdata;
		end
	end

	// hand fetched character to waiting module, ack input modules
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			link.out_load <= '0;
			link.out_char <= CAT_CHAR_ZERO;
			link.in_ack <= '0;
		end else begin
			link.out_load <= '0;
			link.in_ack <= '0;
			if (state_reg == CAT_HAND) begin
				link.out_load[scan_reg] <= 1'b1;
				link.out_char <= rdword_reg[line_num[1:0]*CAT_CHAR_W +: CAT_CHAR_W];
			end
			if (state_reg == CAT_SCAN && !link.out_avail[scan_reg] && link.in_ready[scan_reg]) begin
				link.in_ack[scan_reg] <= 1'b1;
			end
		end
	end

	// memory request port
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			link.mem_req <= 1'b0;
			link.mem_we <= 1'b0;
			link.mem_addr <= '0;
			link.mem_wdata <= '0;
			link.mem_wpar <= 1'b0;
		end else if (link.mem_gnt) begin
			link.mem_req <= 1'b0;
		end else if (state_reg == CAT_SCAN && link.out_avail[scan_reg]) begin
			link.mem_req <= 1'b1;
			link.mem_we <= 1'b0;
			link.mem_addr <= char_word_addr(line_num);
		end else if ((state_reg == CAT_HAND) ||
			(state_reg == CAT_SCAN && link.in_ready[scan_reg])) begin
			link.mem_req <= 1'b1;
			link.mem_we <= 1'b1;
			link.mem_wdata <= (state_reg == CAT_HAND) ?
				{15'h0000, CAT_TYPE_OUTPUT, CAT_CHAR_W'(line_num), CAT_CHAR_ZERO} :
				{15'h0000, CAT_TYPE_INPUT, CAT_CHAR_W'(line_num),
				link.in_char[scan_reg*CAT_CHAR_W +: CAT_CHAR_W]};
			link.mem_wpar <= (state_reg == CAT_HAND) ? cat_odd_parity(entry) :
				cat_odd_parity({15'h0000, CAT_TYPE_INPUT, CAT_CHAR_W'(line_num),
				link.in_char[scan_reg*CAT_CHAR_W +: CAT_CHAR_W]});
			// fast output lines use the priority table
			if (state_reg == CAT_HAND && fast_reg) begin
				link.mem_addr <= CAT_PRIO_BASE + CAT_ADDR_W'(priority_table_load_pointer);
			end else begin
				link.mem_addr <= CAT_GEN_BASE + CAT_ADDR_W'(general_table_load_pointer);
			end
		end
	end

	// load pointers step after each entry write; wrap by width
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			priority_table_load_pointer <= '0;
			general_table_load_pointer <= '0;
		end else if (state_reg == CAT_WR_REQ && link.mem_gnt) begin
			if (is_out_reg && fast_reg) begin
				priority_table_load_pointer <= priority_table_load_pointer + 1'b1;
			end else begin
				general_table_load_pointer <= general_table_load_pointer + 1'b1;
			end
		end
	end

	// unload pointers stepped by instruction logic
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			priority_table_unload_pointer <= '0;
			general_table_unload_pointer <= '0;
			busy <= 1'b0;
		end else begin
			if (prio_unload_step) begin
				priority_table_unload_pointer <= priority_table_unload_pointer + 1'b1;
			end
			if (gen_unload_step) begin
				general_table_unload_pointer <= general_table_unload_pointer + 1'b1;
			end
			busy <= (state_reg != CAT_SCAN); // no interrupt output
		end
	end
endmodule
`default_nettype wire

// ==== rtl/cat_pkg.sv ====
// shared constants and types for the channel activity table loader
package cat_pkg;
	localparam int CAT_DATA_W = 32;
	localparam int CAT_ADDR_W = 16;
	localparam int CAT_CHAR_W = 8;
	localparam int CAT_LINE_W = 6;
	localparam int CAT_BASIC_LINES = 4;
	localparam int CAT_MAX_LINES = 64;
	localparam int CAT_PRIO_ENTRIES = 128;
	localparam int CAT_GEN_ENTRIES = 256;
	localparam int CAT_PRIO_PTR_W = 7;
	localparam int CAT_GEN_PTR_W = 8;
	localparam int CAT_TYPE_BIT = 16;
	localparam int CAT_LINE_LSB = 8;
	localparam int CAT_CHAR_LSB = 0;
	localparam logic [CAT_ADDR_W-1:0] CAT_PRIO_BASE = 16'h0100;
	localparam logic [CAT_ADDR_W-1:0] CAT_GEN_BASE = 16'h0200;
	localparam logic [CAT_ADDR_W-1:0] CAT_LOCT_BASE = 16'h0300;
	localparam logic CAT_TYPE_INPUT = 1'h0;
	localparam logic CAT_TYPE_OUTPUT = 1'h1;
	localparam logic [CAT_CHAR_W-1:0] CAT_CHAR_ZERO = 8'h00;
	typedef enum logic [2:0] {
		CAT_SCAN = 3'b000,
		CAT_RD_REQ = 3'b001,
		CAT_RD_WAIT = 3'b010,
		CAT_HAND = 3'b011,
		CAT_WR_REQ = 3'b100,
		CAT_RELEASE = 3'b101
	} cat_state_t;
	function automatic logic cat_odd_parity(input logic [CAT_DATA_W-1:0] w);
		cat_odd_parity = ~(^w);
	endfunction
endpackage

// ==== rtl/cat_link_if.sv ====
// interface joining the loader to the line modules and core memory
`timescale 1ns/10ps
`default_nettype none
interface cat_link_if #(parameter int LINES = cat_pkg::CAT_BASIC_LINES);
	logic [LINES-1:0] in_ready;
	logic [LINES*cat_pkg::CAT_CHAR_W-1:0] in_char;
	logic [LINES-1:0] in_ack;
	logic [LINES-1:0] out_avail;
	logic [LINES-1:0] out_fast;
	logic [LINES-1:0] out_load;
	logic [cat_pkg::CAT_CHAR_W-1:0] out_char;
	logic mem_req;
	logic mem_we;
	logic [cat_pkg::CAT_ADDR_W-1:0] mem_addr;
	logic [cat_pkg::CAT_DATA_W-1:0] mem_wdata;
	logic mem_wpar;
	logic mem_gnt;
	logic mem_rvalid;
	logic [cat_pkg::CAT_DATA_W-1:0] mem_rdata;
	modport loader (
		input in_ready, in_char, out_avail, out_fast, mem_gnt, mem_rvalid, mem_rdata,
		output in_ack, out_load, out_char, mem_req, mem_we, mem_addr, mem_wdata, mem_wpar
	);
	modport lines (
		output in_ready, in_char, out_avail, out_fast, mem_gnt, mem_rvalid, mem_rdata,
		input in_ack, out_load, out_char, mem_req, mem_we, mem_addr, mem_wdata, mem_wpar
	);
endinterface
`default_nettype wire

// ==== rtl/cat_lines_end.sv ====
// far end: line modules holding one character each plus shared core memory port
`timescale 1ns/10ps
`default_nettype none
module cat_lines_end #(
	parameter int LINES = cat_pkg::CAT_BASIC_LINES,
	parameter int MEM_WORDS = 1024
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	cat_link_if.lines link,
	input wire logic [LINES-1:0] rx_done,
	input wire logic [LINES*cat_pkg::CAT_CHAR_W-1:0] rx_char,
	input wire logic [LINES-1:0] tx_done,
	input wire logic [LINES-1:0] line_fast,
	input wire logic cpu_busy,
	input wire logic sw_we,
	input wire logic [cat_pkg::CAT_ADDR_W-1:0] sw_addr,
	input wire logic [cat_pkg::CAT_DATA_W-1:0] sw_wdata,
	output logic [LINES-1:0] tx_start,
	output logic [LINES*cat_pkg::CAT_CHAR_W-1:0] tx_char,
	output logic [LINES-1:0] rx_taken
);
	import cat_pkg::*;
	localparam int MW = $clog2(MEM_WORDS);
	logic [CAT_DATA_W:0] mem [MEM_WORDS];
	logic [LINES-1:0] in_full_reg;
	logic [LINES*CAT_CHAR_W-1:0] in_hold_reg;
	logic [LINES-1:0] out_idle_reg;
	logic gnt_reg;
	logic rvalid_reg;
	logic [CAT_DATA_W-1:0] rdata_reg;
	logic pend_reg;

	// each input module holds one assembled character until taken
	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					in_full_reg[g] <= 1'b0;
					in_hold_reg[g*CAT_CHAR_W +: CAT_CHAR_W] <= CAT_CHAR_ZERO;
					out_idle_reg[g] <= 1'b0;
					tx_start[g] <= 1'b0;
					tx_char[g*CAT_CHAR_W +: CAT_CHAR_W] <= CAT_CHAR_ZERO;
					rx_taken[g] <= 1'b0;
				end else begin
					rx_taken[g] <= link.in_ack[g];
					tx_start[g] <= link.out_load[g];
					if (rx_done[g]) begin
						in_full_reg[g] <= 1'b1;
						in_hold_reg[g*CAT_CHAR_W +: CAT_CHAR_W] <= rx_char[g*CAT_CHAR_W +: CAT_CHAR_W];
					end else if (link.in_ack[g]) begin
						in_full_reg[g] <= 1'b0;
					end
					if (tx_done[g]) begin
						out_idle_reg[g] <= 1'b1;
					end else if (link.out_load[g]) begin
						out_idle_reg[g] <= 1'b0;
						tx_char[g*CAT_CHAR_W +: CAT_CHAR_W] <= link.out_char;
					end
				end
			end
		end
	endgenerate
	assign link.in_ready = in_full_reg;
	assign link.in_char = in_hold_reg;
	assign link.out_avail = out_idle_reg;
	assign link.out_fast = line_fast;

	// core memory: processor has priority, loader steals free cycles
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			gnt_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			gnt_reg <= link.mem_req && !cpu_busy && !gnt_reg;
			pend_reg <= link.mem_req && !cpu_busy && !gnt_reg && !link.mem_we;
		end
	end
	assign link.mem_gnt = gnt_reg;
	always_ff @(posedge clk_sys) begin
		if (sw_we) begin
			mem[sw_addr[MW-1:0]] <= {sw_wdata, cat_odd_parity(sw_wdata)};
		end else if (gnt_reg && link.mem_we) begin
			mem[link.mem_addr[MW-1:0]] <= {link.mem_wdata, link.mem_wpar};
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			rvalid_reg <= pend_reg;
			if (pend_reg) begin
				rdata_reg <= mem[link.mem_addr[MW-1:0]][CAT_DATA_W:1];
			end
		end
	end
	assign link.mem_rvalid = rvalid_reg;
	assign link.mem_rdata = rdata_reg;
endmodule
`default_nettype wire

// ==== dv/cat_assertions.sv ====
// concurrent checks on the loader link
`timescale 1ns/10ps
`default_nettype none
module cat_assertions #(parameter int LINES = 4) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [LINES-1:0] in_ready,
	input wire logic [LINES*8-1:0] in_char,
	input wire logic [LINES-1:0] in_ack,
	input wire logic [LINES-1:0] out_avail,
	input wire logic [LINES-1:0] out_fast,
	input wire logic [LINES-1:0] out_load,
	input wire logic [7:0] out_char,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_wpar,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata
);
	import cat_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire wr = mem_req && mem_we;
	chk_wr_parity: assert property (wr |-> ^{mem_wdata, mem_wpar})
		else $error("write parity even");
	chk_req_held: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr))
		else $error("request dropped before grant");
	chk_gnt_bound: assert property ($rose(mem_req) |-> ##[1:40] mem_gnt)
		else $error("no grant");
	chk_entry_upper: assert property (wr |-> mem_wdata[31:17] == 15'h0)
		else $error("entry upper bits set");
	chk_req_char: assert property (wr && mem_wdata[16] |-> mem_wdata[7:0] == 8'h00)
		else $error("request char not zero");
	chk_input_general: assert property (wr && !mem_wdata[16] |->
		mem_addr[15:8] == CAT_GEN_BASE[15:8])
		else $error("input not in general table");
	chk_fast_prio: assert property (wr && mem_wdata[16] |->
		(mem_addr[15:7] == CAT_PRIO_BASE[15:7]) == out_fast[mem_wdata[15:8]])
		else $error("request in wrong table");
	chk_rd_char_tab: assert property (mem_req && !mem_we |->
		mem_addr[15:4] == CAT_LOCT_BASE[15:4])
		else $error("read outside char table");
	chk_load_follows: assert property (mem_rvalid |-> ##2 $onehot(out_load))
		else $error("no load after read");
	chk_one_served: assert property ($onehot0({in_ack, out_load}))
		else $error("two lines served");
	chk_ack_write: assert property (in_ack != 0 |-> wr && !mem_wdata[16])
		else $error("ack without input write");
	cover property (mem_gnt && mem_we && mem_wdata[16]);
	cover property (mem_gnt && mem_we && !mem_wdata[16]);
	cover property (out_load != 0);
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench joining loader and line end
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cat_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] rx_done = 4'h0;
	logic [31:0] rx_char = 32'h0;
	logic [3:0] tx_done = 4'h0;
	logic [3:0] line_fast = 4'h5;
	logic cpu_busy = 1'b0;
	logic sw_we = 1'b0;
	logic [15:0] sw_addr = 16'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic prio_step = 1'b0;
	logic gen_step = 1'b0;
	logic [3:0] tx_start;
	logic [31:0] tx_char;
	logic [3:0] rx_taken;
	logic [6:0] lpp;
	logic [7:0] lpg;
	logic [6:0] upp;
	logic [7:0] upg;
	logic busy;
	int n_errors = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_taken = 0;
	logic [6:0] p = 7'h0;
	logic [7:0] g = 8'h0;
	logic [47:0] q[$];
	always #4 clk_sys = ~clk_sys;
	cat_link_if #(.LINES(4)) link ();
	cat_loader cat_loader_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
		.prio_unload_step(prio_step), .gen_unload_step(gen_step),
		.priority_table_load_pointer(lpp), .general_table_load_pointer(lpg),
		.priority_table_unload_pointer(upp), .general_table_unload_pointer(upg), .busy(busy));
	cat_lines_end cat_lines_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
		.rx_done(rx_done), .rx_char(rx_char), .tx_done(tx_done), .line_fast(line_fast),
		.cpu_busy(cpu_busy), .sw_we(sw_we), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.tx_start(tx_start), .tx_char(tx_char), .rx_taken(rx_taken));
	cat_assertions #(.LINES(4)) cat_assertions_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.in_ready(link.in_ready), .in_char(link.in_char), .in_ack(link.in_ack),
		.out_avail(link.out_avail), .out_fast(link.out_fast), .out_load(link.out_load),
		.out_char(link.out_char), .mem_req(link.mem_req), .mem_we(link.mem_we),
		.mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .mem_wpar(link.mem_wpar),
		.mem_gnt(link.mem_gnt), .mem_rvalid(link.mem_rvalid), .mem_rdata(link.mem_rdata));
	// record every granted table write and count the line-side pulses
	always @(posedge clk_sys) begin
		if (link.mem_req && link.mem_we && link.mem_gnt) q.push_back({link.mem_addr, link.mem_wdata});
		if (reset_n) begin
			n_start += $countones(tx_start);
			n_taken += $countones(rx_taken);
		end
	end
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [31:0] ent(input logic t, input logic [7:0] l, input logic [7:0] c);
		return {15'h0, t, l, c};
	endfunction
	task automatic wait_wr(input int n);
		int k;
		k = 0;
		while (q.size() < n && k < 300) begin
			tick();
			k++;
		end
		chk("write count", 48'(q.size()), 48'(n));
		repeat (3) tick();
	endtask
	task automatic pop(input logic [15:0] a, input logic [31:0] d);
		chk("entry", q.pop_front(), {a, d});
	endtask
	task automatic t_rx;
		logic [1:0] s;
		logic [1:0] ln;
		rx_char = 32'hA4B3C2D1;
		rx_done = 4'hF;
		tick();
		rx_done = 4'h0;
		wait_wr(4);
		// the scanner runs free, so service starts anywhere but must then rotate
		s = q[0][9:8];
		for (int k = 0; k < 4; k++) begin
			ln = s + 2'(k);
			pop(CAT_GEN_BASE + 16'(g), ent(CAT_TYPE_INPUT, 8'(ln), rx_char[8*ln +: 8]));
			g++;
		end
		chk("gen ptr", 48'(lpg), 48'(g));
		chk("rx taken", 48'(n_taken), 48'h4);
	endtask
	task automatic t_tx;
		logic [1:0] s;
		logic [1:0] ln;
		sw_we = 1'b1;
		sw_addr = CAT_LOCT_BASE;
		sw_wdata = 32'h44332211;
		tick();
		sw_we = 1'b0;
		tx_done = 4'hF;
		tick();
		tx_done = 4'h0;
		wait_wr(4);
		s = q[0][9:8];
		for (int k = 0; k < 4; k++) begin
			ln = s + 2'(k);
			if (line_fast[ln]) begin
				pop(CAT_PRIO_BASE + 16'(p), ent(CAT_TYPE_OUTPUT, 8'(ln), 8'h00));
				p++;
			end else begin
				pop(CAT_GEN_BASE + 16'(g), ent(CAT_TYPE_OUTPUT, 8'(ln), 8'h00));
				g++;
			end
		end
		chk("tx chars", 48'(tx_char), 48'h44332211);
		chk("prio ptr", 48'(lpp), 48'(p));
		chk("tx starts", 48'(n_start), 48'h4);
	endtask
	task automatic t_stall;
		cpu_busy = 1'b1;
		rx_char[15:8] = 8'h5A;
		rx_done = 4'h2;
		tick();
		rx_done = 4'h0;
		repeat (12) tick();
		chk("stalled writes", 48'(q.size()), 48'h0);
		cpu_busy = 1'b0;
		wait_wr(1);
		pop(CAT_GEN_BASE + 16'(g), ent(CAT_TYPE_INPUT, 8'h01, 8'h5A));
		g++;
	endtask
	task automatic t_wrap;
		for (int i = 0; i < CAT_GEN_ENTRIES; i++) begin
			rx_char[23:16] = 8'(i);
			rx_done = 4'h4;
			tick();
			rx_done = 4'h0;
			wait_wr(1);
			pop(CAT_GEN_BASE + 16'(g), ent(CAT_TYPE_INPUT, 8'h02, 8'(i)));
			g++;
		end
		for (int i = 0; i < CAT_PRIO_ENTRIES; i++) begin
			tx_done = 4'h1;
			tick();
			tx_done = 4'h0;
			wait_wr(1);
			pop(CAT_PRIO_BASE + 16'(p), ent(CAT_TYPE_OUTPUT, 8'h00, 8'h00));
			p++;
		end
	endtask
	task automatic t_unload;
		repeat (3) begin
			prio_step = 1'b1;
			tick();
			prio_step = 1'b0;
			gen_step = 1'b1;
			tick();
			gen_step = 1'b0;
		end
		chk("unload ptrs", 48'({upp, upg}), 48'({7'h03, 8'h03}));
		chk("load ptrs", 48'({lpp, lpg}), 48'({p, g}));
	endtask
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		tick();
		chk("reset", 48'({lpp, lpg, upp, upg, busy}), 48'h0);
		t_rx();
		t_tx();
		t_stall();
		t_wrap();
		t_unload();
		wrap_up();
	end
endmodule
`default_nettype wire
